// ==== bbs_axil_slave.sv ====
// axi4-lite slave front end that turns bus transfers into register requests
`timescale 1ns/1ns
`default_nettype none
module bbs_axil_slave
  import bbs_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // write channels
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // read channels
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // register side
  output bbs_req_t req,
  input wire logic [31:0] rd_data
);

  logic aw_got_r, aw_got_nxt, w_got_r, w_got_nxt, bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
  logic [ADDR_W-1:0] awaddr_r, awaddr_nxt;
  logic [31:0] wdata_r, wdata_nxt, rdata_r, rdata_nxt;
  logic [3:0] wstrb_r, wstrb_nxt;
  logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic do_wr;

  // each write channel is taken once and held until the write is issued
  assign awready = !aw_got_r && !bvalid_r;
  assign wready = !w_got_r && !bvalid_r;
  assign arready = !rvalid_r;
  assign do_wr = aw_got_r && w_got_r && !bvalid_r;
  assign req = '{wr: do_wr, waddr: awaddr_r, wdata: wdata_r, wstrb: wstrb_r, raddr: araddr};
  assign bvalid = bvalid_r;
  assign bresp = bresp_r;
  assign rvalid = rvalid_r;
  assign rdata = rdata_r;
  assign rresp = rresp_r;

  // ----------------------------------------------------------------
  // next state of both directions
  // ----------------------------------------------------------------
  always_comb begin
    aw_got_nxt = aw_got_r;
    w_got_nxt = w_got_r;
    awaddr_nxt = awaddr_r;
    wdata_nxt = wdata_r;
    wstrb_nxt = wstrb_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    rvalid_nxt = rvalid_r;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    if (awvalid && awready) begin
      aw_got_nxt = 1'b1;
      awaddr_nxt = awaddr;
    end
    if (wvalid && wready) begin
      w_got_nxt = 1'b1;
      wdata_nxt = wdata;
      wstrb_nxt = wstrb;
    end
    if (do_wr) begin
      aw_got_nxt = 1'b0;
      w_got_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = reg_mapped(awaddr_r) ? RESP_OKAY : RESP_SLVERR;
    end else if (bvalid_r && bready) begin
      bvalid_nxt = 1'b0;
    end
    // read data is sampled at the address handshake, so it is a snapshot
    if (arvalid && arready) begin
      rvalid_nxt = 1'b1;
      rdata_nxt = rd_data;
      rresp_nxt = reg_mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_r && rready) begin
      rvalid_nxt = 1'b0;
    end
  end

  // register stage
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      awaddr_r <= '0;
      wdata_r <= '0;
      wstrb_r <= '0;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
      rvalid_r <= 1'b0;
      rdata_r <= '0;
      rresp_r <= RESP_OKAY;
    end else begin
      aw_got_r <= aw_got_nxt;
      w_got_r <= w_got_nxt;
      awaddr_r <= awaddr_nxt;
      wdata_r <= wdata_nxt;
      wstrb_r <= wstrb_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
    end
  end

endmodule
`default_nettype wire

// ==== bbs_core.sv ====
// branch and bit-set execution core with its register file and data memory
//
// The AXI4-Lite slave port and the address map are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module bbs_core
  import bbs_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  bbs_req_t req;
  logic [31:0] rd_data;
  bbs_state_t state_r, state_nxt;
  bbs_op_t op_r, op_nxt;
  logic nop_r, nop_nxt, taken_r, taken_nxt, illegal_r, illegal_nxt, zero_r, zero_nxt;
  logic [PC_W-1:0] pc_r, pc_nxt, tgt_r, tgt_nxt;
  logic [15:0] instr_r, instr_nxt;
  logic [BANK_W-1:0] bank_r, bank_nxt;
  logic [DADDR_W-1:0] maddr_r, maddr_nxt;
  logic [1:0] cyc_r, cyc_nxt;
  logic [7:0] dat_r, dat_nxt;
  logic [7:0] dmem [0:(1<<DADDR_W)-1];
  logic [DADDR_W-1:0] eff_addr, mem_wa;
  logic [7:0] mem_wd, bit_mask;
  logic mem_we, idle, wr_hit, start;
  logic [31:0] wmerged;

  bbs_axil_slave u_slave (
    .aclk(aclk),
    .aresetn(aresetn),
    .awaddr(s_axi_awaddr),
    .awvalid(s_axi_awvalid),
    .awready(s_axi_awready),
    .wdata(s_axi_wdata),
    .wstrb(s_axi_wstrb),
    .wvalid(s_axi_wvalid),
    .wready(s_axi_wready),
    .bresp(s_axi_bresp),
    .bvalid(s_axi_bvalid),
    .bready(s_axi_bready),
    .araddr(s_axi_araddr),
    .arvalid(s_axi_arvalid),
    .arready(s_axi_arready),
    .rdata(s_axi_rdata),
    .rresp(s_axi_rresp),
    .rvalid(s_axi_rvalid),
    .rready(s_axi_rready),
    .req(req),
    .rd_data(rd_data)
  );

  // ----------------------------------------------------------------
  // operand decode
  // ----------------------------------------------------------------
  assign idle = (state_r == ST_IDLE);
  assign wr_hit = req.wr && idle; // setup registers are frozen while an instruction runs
  assign start = wr_hit && (req.waddr == OFS_CTRL) && req.wstrb[0]
                 && req.wdata[CTRL_START_BIT];
  assign bit_mask = 8'h01 << instr_r[11:9];
  // bank bit low: fixed access bank; high: bank select register
  assign eff_addr = instr_r[8] ? {bank_r, instr_r[7:0]} : {ACCESS_BANK, instr_r[7:0]};
  assign mem_we = (state_r == ST_Q4) && !nop_r && (op_r == OP_BSET);
  assign mem_wa = eff_addr;
  assign mem_wd = dat_r;

  always_comb begin
    unique case (req.waddr)
      OFS_PC: wmerged = merge_strb({11'h000, pc_r}, req.wdata, req.wstrb);
      OFS_BANK: wmerged = merge_strb({28'h0000000, bank_r}, req.wdata, req.wstrb);
      OFS_MADDR: wmerged = merge_strb({20'h00000, maddr_r}, req.wdata, req.wstrb);
      OFS_STATUS: wmerged = merge_strb({31'h00000000, zero_r}, req.wdata, req.wstrb);
      default: wmerged = merge_strb({16'h0000, instr_r}, req.wdata, req.wstrb);
    endcase
  end

  // ----------------------------------------------------------------
  // execution sequencer: one clock per phase
  // ----------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    op_nxt = op_r;
    nop_nxt = nop_r;
    taken_nxt = taken_r;
    illegal_nxt = illegal_r;
    zero_nxt = zero_r;
    pc_nxt = pc_r;
    tgt_nxt = tgt_r;
    instr_nxt = instr_r;
    bank_nxt = bank_r;
    maddr_nxt = maddr_r;
    cyc_nxt = cyc_r;
    dat_nxt = dat_r;
    // software setup only while idle
    if (wr_hit) begin
      unique case (req.waddr)
        OFS_INSTR: instr_nxt = wmerged[15:0];
        OFS_PC: pc_nxt = wmerged[PC_W-1:0];
        OFS_BANK: bank_nxt = wmerged[BANK_W-1:0];
        OFS_MADDR: maddr_nxt = wmerged[DADDR_W-1:0];
        OFS_STATUS: zero_nxt = wmerged[ST_ZERO_BIT]; // only software moves the zero flag
        default: ;
      endcase
    end
    unique case (state_r)
      ST_IDLE: begin
        if (start) begin
          state_nxt = ST_Q1;
          nop_nxt = 1'b0;
          taken_nxt = 1'b0;
          illegal_nxt = 1'b0;
          cyc_nxt = 2'h0;
        end
      end
      ST_Q1: begin // decode; pc moves past the branch word
        state_nxt = ST_Q2;
        if (!nop_r) begin
          op_nxt = decode_op(instr_r);
          illegal_nxt = (decode_op(instr_r) == OP_NONE);
          pc_nxt = pc_r + PC_STEP;
        end
      end
      ST_Q2: begin // read literal or register
        state_nxt = ST_Q3;
        if (!nop_r && op_r == OP_BSET) begin
          dat_nxt = dmem[eff_addr];
        end
      end
      ST_Q3: begin // process data
        state_nxt = ST_Q4;
        if (!nop_r) begin
          dat_nxt = dat_r | bit_mask;
          tgt_nxt = pc_r + branch_ofs(instr_r);
          taken_nxt = (op_r == OP_BRA) || (op_r == OP_BZC && !zero_r);
        end
      end
      ST_Q4: begin // write pc; a taken branch spends a second, empty cycle
        if (nop_r) begin
          state_nxt = ST_IDLE;
          nop_nxt = 1'b0;
          cyc_nxt = CYC_TWO;
        end else if (taken_r) begin
          pc_nxt = tgt_r;
          state_nxt = ST_Q1;
          nop_nxt = 1'b1;
        end else begin
          state_nxt = ST_IDLE;
          cyc_nxt = CYC_ONE;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= ST_IDLE;
      op_r <= OP_NONE;
      nop_r <= 1'b0;
      taken_r <= 1'b0;
      illegal_r <= 1'b0;
      zero_r <= 1'b0;
      pc_r <= PC_RST;
      tgt_r <= PC_RST;
      instr_r <= INSTR_RST;
      bank_r <= BANK_RST;
      maddr_r <= '0;
      cyc_r <= 2'h0;
      dat_r <= 8'h00;
    end else begin
      state_r <= state_nxt;
      op_r <= op_nxt;
      nop_r <= nop_nxt;
      taken_r <= taken_nxt;
      illegal_r <= illegal_nxt;
      zero_r <= zero_nxt;
      pc_r <= pc_nxt;
      tgt_r <= tgt_nxt;
      instr_r <= instr_nxt;
      bank_r <= bank_nxt;
      maddr_r <= maddr_nxt;
      cyc_r <= cyc_nxt;
      dat_r <= dat_nxt;
    end
  end

  // data memory: core writes in q4, software through the data window when idle
  always_ff @(posedge aclk) begin
    if (mem_we) begin
      dmem[mem_wa] <= mem_wd;
    end else if (wr_hit && req.waddr == OFS_MDATA && req.wstrb[0]) begin
      dmem[maddr_r] <= req.wdata[7:0];
    end
  end

  // ----------------------------------------------------------------
  // register read mux
  // ----------------------------------------------------------------
  always_comb begin
    rd_data = 32'h00000000;
    unique case (req.raddr)
      OFS_INSTR: rd_data = {16'h0000, instr_r};
      OFS_PC: rd_data = {11'h000, pc_r};
      OFS_STATUS: rd_data = {28'h0000000, illegal_r, taken_r, !idle, zero_r};
      OFS_BANK: rd_data = {28'h0000000, bank_r};
      OFS_MADDR: rd_data = {20'h00000, maddr_r};
      OFS_MDATA: rd_data = {24'h000000, dmem[maddr_r]};
      OFS_CYCLES: rd_data = {30'h00000000, cyc_r};
      default: rd_data = 32'h00000000;
    endcase
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  AST_BZC_TAKEN: assert property (@(posedge aclk) disable iff (!aresetn)
    (state_r == ST_Q3 && !nop_r && op_r == OP_BZC) |=> (taken_r == !$past(zero_r)))
    else $error("zero-clear branch decision wrong");
  AST_BZC_TARGET: assert property (@(posedge aclk) disable iff (!aresetn)
    (state_r == ST_Q1 && !nop_r && decode_op(instr_r) == OP_BZC && !zero_r)
    |=> ##3 (pc_r == $past(pc_r, 4) + PC_STEP + branch_ofs($past(instr_r, 4))))
    else $error("zero-clear branch target wrong");
  AST_ONE_CYCLE: assert property (@(posedge aclk) disable iff (!aresetn)
    (state_r == ST_Q1 && !nop_r && decode_op(instr_r) == OP_BZC && zero_r)
    |=> ##3 (idle && cyc_r == CYC_ONE && pc_r == $past(pc_r, 4) + PC_STEP))
    else $error("untaken branch not one cycle");
  AST_BRA_TARGET: assert property (@(posedge aclk) disable iff (!aresetn)
    (state_r == ST_Q1 && !nop_r && decode_op(instr_r) == OP_BRA)
    |=> ##3 (pc_r == $past(pc_r, 4) + PC_STEP + branch_ofs($past(instr_r, 4))))
    else $error("always-branch target wrong");
  AST_TWO_CYCLES: assert property (@(posedge aclk) disable iff (!aresetn)
    (state_r == ST_Q3 && !nop_r && op_r == OP_BRA)
    |=> taken_r ##1 (nop_r && state_r == ST_Q1) ##4 (idle && cyc_r == CYC_TWO))
    else $error("always-branch not two cycles");
  AST_DECODE: assert property (@(posedge aclk) disable iff (!aresetn)
    (state_r == ST_Q2 && !nop_r) |-> (op_r == decode_op(instr_r)
    && illegal_r == (op_r == OP_NONE)))
    else $error("opcode decode wrong");
  AST_BIT_SET: assert property (@(posedge aclk) disable iff (!aresetn)
    mem_we |-> (mem_wd == ($past(dat_r) | bit_mask)))
    else $error("bit set value wrong");
  AST_ACCESS_BANK: assert property (@(posedge aclk) disable iff (!aresetn)
    (mem_we && !instr_r[8]) |-> (mem_wa == {ACCESS_BANK, instr_r[7:0]}))
    else $error("access bank not used");
  AST_BANKED: assert property (@(posedge aclk) disable iff (!aresetn)
    (mem_we && instr_r[8]) |-> (mem_wa == {bank_r, instr_r[7:0]}))
    else $error("bank select not used");
  AST_NO_FLAGS: assert property (@(posedge aclk) disable iff (!aresetn)
    !idle |=> $stable(zero_r))
    else $error("status flag changed by execution");
  AST_PHASES: assert property (@(posedge aclk) disable iff (!aresetn)
    (state_r == ST_Q1) |=> (state_r == ST_Q2) ##1 (state_r == ST_Q3) ##1 (state_r == ST_Q4))
    else $error("phase order wrong");
  AST_RMW: assert property (@(posedge aclk) disable iff (!aresetn)
    (state_r == ST_Q2 && !nop_r && op_r == OP_BSET) |-> ##2 mem_we ##1 (idle && cyc_r == CYC_ONE))
    else $error("bit set not single cycle");

  // start and end of each instruction cycle: where the pc goes and what the empty cycle may touch
  AST_START_Q1: assert property (@(posedge aclk) disable iff (!aresetn)
    start |=> (state_r == ST_Q1 && !nop_r))
    else $error("start did not enter decode phase");
  AST_UNTAKEN_ENDS: assert property (@(posedge aclk) disable iff (!aresetn)
    (state_r == ST_Q4 && !nop_r && !taken_r) |=> (idle && cyc_r == CYC_ONE))
    else $error("untaken instruction did not end after one cycle");
  AST_TAKEN_PC: assert property (@(posedge aclk) disable iff (!aresetn)
    (state_r == ST_Q4 && !nop_r && taken_r) |=> (nop_r && pc_r == $past(tgt_r)))
    else $error("taken branch did not load pc in last phase");
  AST_NOP_PC_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
    nop_r |=> $stable(pc_r))
    else $error("pc moved during the empty cycle");
  AST_ILLEGAL_QUIET: assert property (@(posedge aclk) disable iff (!aresetn)
    (state_r == ST_Q4 && !nop_r && op_r == OP_NONE) |-> (!mem_we && !taken_r))
    else $error("unknown opcode had an effect");
  AST_BSET_NO_BRANCH: assert property (@(posedge aclk) disable iff (!aresetn)
    (state_r == ST_Q4 && !nop_r && op_r == OP_BSET) |-> !taken_r)
    else $error("bit set redirected the pc");

endmodule
`default_nettype wire

// ==== bbs_core_test.sv ====
// self-checking testbench for the branch and bit-set execution core over axi4-lite
`timescale 1ns/1ns
`default_nettype none
module bbs_core_test;
  import bbs_pkg::*;

  // ----------------------------------------------------------------
  // clock, reset and bus signals
  // ----------------------------------------------------------------
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [ADDR_W-1:0] awaddr = '0;
  logic awvalid = 1'b0;
  logic [31:0] wdata = '0;
  logic [3:0] wstrb = '0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic [ADDR_W-1:0] araddr = '0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  int mismatches = 0;
  int samples_checked = 0;

  // 100 ns period
  always #50 aclk = ~aclk;

  bbs_core dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready)
  );

  // ----------------------------------------------------------------
  // bus tasks
  // ----------------------------------------------------------------
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // handshakes are judged at the falling edge, where the readies have settled for the next rise
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
    logic ah, wh, bh;
    int n;
    n = 0;
    bh = 1'b0;
    resp = 2'h3;
    @(posedge aclk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wstrb <= 4'hf;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!bh && n < 100) begin
      @(negedge aclk);
      ah = awvalid && awready;
      wh = wvalid && wready;
      bh = bvalid && bready;
      if (bh) resp = bresp;
      @(posedge aclk);
      if (ah) awvalid <= 1'b0;
      if (wh) wvalid <= 1'b0;
      if (bh) bready <= 1'b0;
      n++;
    end
    if (!bh) check("write response wait", 32'h0, 32'h1);
  endtask

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
    logic ah, rh;
    int n;
    n = 0;
    rh = 1'b0;
    d = '0;
    resp = 2'h3;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!rh && n < 100) begin
      @(negedge aclk);
      ah = arvalid && arready;
      rh = rvalid && rready;
      if (rh) begin
        d = rdata;
        resp = rresp;
      end
      @(posedge aclk);
      if (ah) arvalid <= 1'b0;
      if (rh) rready <= 1'b0;
      n++;
    end
    if (!rh) check("read data wait", 32'h0, 32'h1);
  endtask

  // wr/rd with okay checked; keeps the scenarios short
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    axi_write(a, d, r);
    check("bresp", {30'h0, r}, {30'h0, RESP_OKAY});
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    logic [1:0] r;
    axi_read(a, d, r);
    check("rresp", {30'h0, r}, {30'h0, RESP_OKAY});
  endtask

  // load one instruction, start it and poll busy under a bound
  task automatic run(input logic [15:0] ins, input logic [20:0] pc, input logic z);
    logic [31:0] s;
    int n;
    wr(OFS_INSTR, {16'h0, ins});
    wr(OFS_PC, {11'h0, pc});
    wr(OFS_STATUS, {31'h0, z});
    wr(OFS_CTRL, 32'h1);
    n = 0;
    s = 32'h2;
    while (s[ST_BUSY_BIT] !== 1'b0 && n < 20) begin
      rd(OFS_STATUS, s);
      n++;
    end
    check("busy clears", {31'h0, s[ST_BUSY_BIT]}, 32'h0);
  endtask

  task automatic finish_test;
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // scenario tables
  // ----------------------------------------------------------------
  // branches at both offset limits, the untaken case and an illegal word
  logic [15:0] b_ins [6] = '{16'he17f, 16'he180, 16'he17f, 16'hd3ff, 16'hd400, 16'h0000};
  logic [20:0] b_pc [6] = '{21'h100, 21'h100, 21'h100, 21'h1000, 21'h1000, 21'h40};
  logic b_z [6] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1};
  logic [20:0] b_exp [6] = '{21'h200, 21'h002, 21'h102, 21'h1800, 21'h802, 21'h42};
  logic [1:0] b_cyc [6] = '{CYC_TWO, CYC_TWO, CYC_ONE, CYC_TWO, CYC_TWO, CYC_ONE};
  logic b_tk [6] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
  // bit set: access bank, banked, top bit index and top address
  logic [15:0] s_ins [3] = '{16'h8eab, 16'h81ab, 16'h87ff};
  logic [3:0] s_bank [3] = '{4'h5, 4'h5, 4'hf};
  logic [11:0] s_tgt [3] = '{12'h0ab, 12'h5ab, 12'hfff};
  logic [11:0] s_oth [3] = '{12'h5ab, 12'h0ab, 12'h0ff};
  logic [7:0] s_pre [3] = '{8'h0a, 8'h0a, 8'hf0};
  logic [7:0] s_exp [3] = '{8'h8a, 8'h0b, 8'hf8};

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] v;
    logic [1:0] r;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    // reset values
    rd(OFS_PC, v);
    check("pc reset", v, 32'h0);
    rd(OFS_CYCLES, v);
    check("cycles reset", v, 32'h0);
    // branches: target, cycle count, taken flag, zero flag left alone
    for (int i = 0; i < 6; i++) begin
      run(b_ins[i], b_pc[i], b_z[i]);
      rd(OFS_PC, v);
      check("branch pc", v, {11'h0, b_exp[i]});
      rd(OFS_CYCLES, v);
      check("branch cycles", v, {30'h0, b_cyc[i]});
      rd(OFS_STATUS, v);
      check("branch taken", {31'h0, v[ST_TAKEN_BIT]}, {31'h0, b_tk[i]});
      check("branch zero", {31'h0, v[ST_ZERO_BIT]}, {31'h0, b_z[i]});
      check("illegal", {31'h0, v[ST_ILLEGAL_BIT]}, {31'h0, i == 5});
    end
    // bit set: one bit forced, bank chosen by the access bit
    for (int i = 0; i < 3; i++) begin
      wr(OFS_BANK, {28'h0, s_bank[i]});
      wr(OFS_MADDR, {20'h0, s_tgt[i]});
      wr(OFS_MDATA, {24'h0, s_pre[i]});
      wr(OFS_MADDR, {20'h0, s_oth[i]});
      wr(OFS_MDATA, {24'h0, s_pre[i]});
      run(s_ins[i], 21'h80, 1'b1);
      wr(OFS_MADDR, {20'h0, s_tgt[i]});
      rd(OFS_MDATA, v);
      check("set target", v, {24'h0, s_exp[i]});
      wr(OFS_MADDR, {20'h0, s_oth[i]});
      rd(OFS_MDATA, v);
      check("other bank", v, {24'h0, s_pre[i]});
      rd(OFS_CYCLES, v);
      check("set cycles", v, {30'h0, CYC_ONE});
      rd(OFS_PC, v);
      check("set pc", v, 32'h82);
      rd(OFS_STATUS, v);
      check("set zero", {31'h0, v[ST_ZERO_BIT]}, 32'h1);
    end
    // unmapped places answer slverr, read data zero
    axi_read(8'h20, v, r);
    check("unmapped rresp", {30'h0, r}, {30'h0, RESP_SLVERR});
    check("unmapped rdata", v, 32'h0);
    axi_write(8'h22, 32'h1, r);
    check("unmapped bresp", {30'h0, r}, {30'h0, RESP_SLVERR});
    finish_test;
  end

  // ----------------------------------------------------------------
  // watchdog: the whole sequence needs a few hundred cycles
  // ----------------------------------------------------------------
  initial begin
    repeat (20000) @(posedge aclk);
    mismatches++;
    finish_test;
  end

endmodule
`default_nettype wire

// ==== bbs_pkg.sv ====
// constants, types and helper functions for the branch and bit-set execution block
//
// Functional notes
// - zero-clear branch 1110 0001 taken when zero clear
// - zero-clear offset signed 8-bit, adds 2n
// - target is branch address plus 2 plus 2n
// - zero-clear branch: one cycle, two when taken
// - always-branch offset signed 11-bit, adds 2n
// - always-branch takes two cycles, second is nop
// - always-branch opcode top nibble 1101
// - bit-set opcode 1000, bit, bank, address fields
// - bit-set forces one bit, others unchanged
// - bank bit 0 selects fixed access bank
// - bank bit 1 uses bank select register
// - none of the three changes status flags
package bbs_pkg;

  // ----------------------------------------------------------------
  // bus and register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_INSTR = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_PC = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_BANK = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_MADDR = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_MDATA = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_CYCLES = 8'h1c;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // field positions
  localparam int CTRL_START_BIT = 0;
  localparam int ST_ZERO_BIT = 0;
  localparam int ST_BUSY_BIT = 1;
  localparam int ST_TAKEN_BIT = 2;
  localparam int ST_ILLEGAL_BIT = 3;

  // ----------------------------------------------------------------
  // core geometry and reset values
  // ----------------------------------------------------------------
  localparam int PC_W = 21;
  localparam int BANK_W = 4;
  localparam int DADDR_W = 12;
  localparam logic [PC_W-1:0] PC_RST = 21'h000000;
  localparam logic [PC_W-1:0] PC_STEP = 21'h000002;
  localparam logic [15:0] INSTR_RST = 16'h0000;
  localparam logic [BANK_W-1:0] BANK_RST = 4'h0;
  localparam logic [BANK_W-1:0] ACCESS_BANK = 4'h0;
  localparam logic [1:0] CYC_ONE = 2'h1;
  localparam logic [1:0] CYC_TWO = 2'h2;

  // opcode patterns
  localparam logic [7:0] OPC_BZC = 8'he1;
  localparam logic [3:0] OPC_BRA = 4'hd;
  localparam logic [3:0] OPC_BSET = 4'h8;

  typedef enum logic [1:0] {OP_NONE, OP_BZC, OP_BRA, OP_BSET} bbs_op_t;

  // gray codes along Q1..Q4
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_Q1 = 3'h1,
    ST_Q2 = 3'h3,
    ST_Q3 = 3'h2,
    ST_Q4 = 3'h6
  } bbs_state_t;

  // register access request from the bus front end
  typedef struct packed {
    logic wr;
    logic [ADDR_W-1:0] waddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic [ADDR_W-1:0] raddr;
  } bbs_req_t;

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  function automatic logic reg_mapped(input logic [ADDR_W-1:0] a);
    reg_mapped = (a[1:0] == 2'h0) && (a <= OFS_CYCLES);
  endfunction

  function automatic logic [31:0] merge_strb(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] strb);
    merge_strb = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        merge_strb[8*i +: 8] = nw[8*i +: 8];
      end
    end
  endfunction

  function automatic bbs_op_t decode_op(input logic [15:0] ins);
    if (ins[15:8] == OPC_BZC) begin
      decode_op = OP_BZC;
    end else if (ins[15:12] == OPC_BRA) begin
      decode_op = OP_BRA;
    end else if (ins[15:12] == OPC_BSET) begin
      decode_op = OP_BSET;
    end else begin
      decode_op = OP_NONE;
    end
  endfunction

  // byte offset 2n for either branch, sign-extended to the pc width
  function automatic logic [PC_W-1:0] branch_ofs(input logic [15:0] ins);
    if (ins[15:8] == OPC_BZC) begin
      branch_ofs = {{(PC_W-9){ins[7]}}, ins[7:0], 1'b0};
    end else begin
      branch_ofs = {{(PC_W-12){ins[10]}}, ins[10:0], 1'b0};
    end
  endfunction

endpackage
